// File: hdl/dlsp_limit_protect.sv
// Purpose: regeneration handling, limit-set switching and protection alarms
// Assumes: APB slave, one wait-free access phase; inputs synchronous to mclk
// Notes: writes are clamped into each parameter's legal range
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module dlsp_limit_protect
	import dlsp_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// drive measurements
	input  wire logic [15:0] speed_rpm,
	input  wire logic [31:0] deviation,
	input  wire logic [7:0]  regen_load_pct,
	input  wire logic        second_torque_sel,
	// drive controls and alarms
	output logic             regen_ext_en,
	output logic             regen_alarm,
	output logic [7:0]       alarm_code,
	output logic [15:0]      torque_limit,
	output logic [31:0]      ovf_threshold,
	output logic             overspeed_err,
	output logic             overflow_err,
	output logic             second_set_active,
	output logic             irq
);
	dlsp_apb_req_t   req;
	dlsp_regen_t     regen_resistor_select;
	logic            limit_switch_select;
	logic [15:0]     first_torque_limit;
	logic [15:0]     first_deviation_overflow_level;
	logic [15:0]     first_overspeed_level;
	logic [15:0]     second_torque_limit;
	logic [15:0]     second_deviation_overflow_level;
	logic [15:0]     second_overspeed_level;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_event;
	logic [IRQ_W-1:0] irq_clear;
	logic            wr_en;
	logic            rd_setup;
	logic            addr_ok;
	logic [31:0]     next_rdata;
	logic [15:0]     wv;
	logic            regen_over;
	dlsp_set_t       set_one;
	dlsp_set_t       set_two;
	dlsp_set_t       active_set;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite,
		paddr: paddr, pwdata: pwdata};
	assign wv  = req.pwdata[15:0];

	// address decode; anything outside the map answers with an error
	always_comb begin
		case (req.paddr)
			OFS_REGEN_SEL, OFS_LIMIT_SW, OFS_TQ1, OFS_OVF1,
			OFS_OSP1, OFS_TQ2, OFS_OVF2, OFS_OSP2,
			OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_LIVE:
				addr_ok = 1'b1;
			default:
				addr_ok = 1'b0;
		endcase
	end

	// read data is captured in the setup cycle so it can come from a flop
	assign pready   = req.psel & req.penable;
	assign pslverr  = pready & ~addr_ok;
	assign wr_en    = pready & req.pwrite & addr_ok;
	assign rd_setup = req.psel & ~req.penable & ~req.pwrite;

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (req.paddr)
			OFS_REGEN_SEL: next_rdata[1:0]  = regen_resistor_select;
			OFS_LIMIT_SW:  next_rdata[0]    = limit_switch_select;
			OFS_TQ1:       next_rdata[15:0] = first_torque_limit;
			OFS_OVF1:      next_rdata[15:0] = first_deviation_overflow_level;
			OFS_OSP1:      next_rdata[15:0] = first_overspeed_level;
			OFS_TQ2:       next_rdata[15:0] = second_torque_limit;
			OFS_OVF2:      next_rdata[15:0] = second_deviation_overflow_level;
			OFS_OSP2:      next_rdata[15:0] = second_overspeed_level;
			OFS_IRQ_STAT:  next_rdata[IRQ_W-1:0] = irq_status;
			OFS_IRQ_MASK:  next_rdata[IRQ_W-1:0] = irq_mask;
			OFS_LIVE:      next_rdata[5:0] = {second_set_active, regen_ext_en,
				regen_alarm, overflow_err, overspeed_err, irq};
			default:       next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			prdata <= 32'h0000_0000;
		else if (rd_setup)
			prdata <= next_rdata;
	end

	// mode and switching registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			regen_resistor_select <= dlsp_regen_t'(RST_REGEN_SEL);
			limit_switch_select   <= 1'b0;
		end else if (wr_en) begin
			if (req.paddr == OFS_REGEN_SEL)
				regen_resistor_select <= dlsp_regen_t'(req.pwdata[1:0]);
			if (req.paddr == OFS_LIMIT_SW)
				limit_switch_select <= req.pwdata[0];
		end
	end

	// first limit set
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			first_torque_limit             <= RST_TQ1;
			first_deviation_overflow_level <= RST_OVF1;
			first_overspeed_level          <= RST_OSP1;
		end else if (wr_en) begin
			case (req.paddr)
				OFS_TQ1:  first_torque_limit <= dlsp_clamp(wv, 16'h0000, MAX_TORQUE);
				OFS_OVF1: first_deviation_overflow_level <= dlsp_clamp(wv, 16'h0000,
					MAX_OVF);
				OFS_OSP1: first_overspeed_level <= dlsp_clamp(wv, 16'h0000,
					MAX_SPEED);
				default: ;
			endcase
		end
	end

	// second limit set; the overflow level never drops below one unit
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			second_torque_limit             <= RST_TQ2;
			second_deviation_overflow_level <= RST_OVF2;
			second_overspeed_level          <= RST_OSP2;
		end else if (wr_en) begin
			case (req.paddr)
				OFS_TQ2:  second_torque_limit <= dlsp_clamp(wv, 16'h0000,
					MAX_TORQUE);
				OFS_OVF2: second_deviation_overflow_level <= dlsp_clamp(wv, MIN_OVF2,
					MAX_OVF);
				OFS_OSP2: second_overspeed_level <= dlsp_clamp(wv, 16'h0000,
					MAX_SPEED);
				default: ;
			endcase
		end
	end

	assign set_one = '{torque_pct: first_torque_limit,
		ospd_level: first_overspeed_level,
		ovf_level: first_deviation_overflow_level};
	assign set_two = '{torque_pct: second_torque_limit,
		ospd_level: second_overspeed_level,
		ovf_level: second_deviation_overflow_level};

	dlsp_set_check u_check (
		.mclk       (mclk),
		.rstn       (rstn),
		.set_one    (set_one),
		.set_two    (set_two),
		.switch_en  (limit_switch_select),
		.second_sel (second_torque_sel),
		.speed_rpm  (speed_rpm),
		.deviation  (deviation),
		.active_set (active_set),
		.ovf_pulses (ovf_threshold),
		.use_second (second_set_active),
		.overspeed  (overspeed_err),
		.overflow   (overflow_err)
	);

	assign torque_limit = active_set.torque_pct;

	// regeneration: only modes 1 and 2 engage the external resistor
	always_comb begin
		case (regen_resistor_select)
			REGEN_EXT_ALARM:   regen_over = regen_load_pct > REGEN_LIMIT;
			REGEN_EXT_NOALARM: regen_over = 1'b0;
			default:           regen_over = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			regen_ext_en <= 1'b0;
			regen_alarm  <= 1'b0;
			alarm_code   <= 8'h00;
		end else begin
			regen_ext_en <= (regen_resistor_select == REGEN_EXT_ALARM) |
				(regen_resistor_select == REGEN_EXT_NOALARM);
			regen_alarm  <= regen_over;
			alarm_code   <= regen_over ? ALARM_REGEN : 8'h00;
		end
	end

	// sticky status; a new event in the clearing cycle keeps the bit set
	assign irq_event[IRQ_REGEN] = regen_alarm;
	assign irq_event[IRQ_OSPD]  = overspeed_err;
	assign irq_event[IRQ_OVF]   = overflow_err;
	assign irq_clear = (wr_en && req.paddr == OFS_IRQ_STAT) ?
		req.pwdata[IRQ_W-1:0] : '0;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			irq_status <= '0;
		else
			irq_status <= (irq_status & ~irq_clear) | irq_event;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			irq_mask <= '0;
		else if (wr_en && req.paddr == OFS_IRQ_MASK)
			irq_mask <= req.pwdata[IRQ_W-1:0];
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end
endmodule

// File: hdl/dlsp_pkg.sv
// Purpose: constants and types for the drive limit-set and protection block
// Assumes: 20 MHz mclk, APB register access with 32-bit data
// Notes: register offsets are byte addresses of aligned words
// Summary of operation
// - selections 0 and 3 keep the external regeneration circuit off.
// - selection 1 uses external resistor; alarm 18 when load exceeds 10 percent.
// - selection 2 uses external resistor and never raises the overload alarm.
// - first overspeed level 0 to 6000 r/min, default 0, used only when switching.
// - first torque limit active: speed above first level gives overspeed error.
// - switching disabled: first overspeed level and second set are ignored.
// - second torque limit 0 to 500 percent, default 100, used when set two applies.
// - second overflow level 1 to 32767 times 256 pulses, default 100.
// - second torque limit active: speed above second level gives overspeed error.
// - first overflow threshold is the programmed level times 256 pulses.
package dlsp_pkg;
	localparam logic [7:0] OFS_REGEN_SEL  = 8'h00;
	localparam logic [7:0] OFS_LIMIT_SW   = 8'h04;
	localparam logic [7:0] OFS_TQ1        = 8'h08;
	localparam logic [7:0] OFS_OVF1       = 8'h0C;
	localparam logic [7:0] OFS_OSP1       = 8'h10;
	localparam logic [7:0] OFS_TQ2        = 8'h14;
	localparam logic [7:0] OFS_OVF2       = 8'h18;
	localparam logic [7:0] OFS_OSP2       = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STAT   = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h24;
	localparam logic [7:0] OFS_LIVE       = 8'h28;

	localparam logic [1:0]  RST_REGEN_SEL = 2'h0;
	localparam logic [15:0] RST_TQ1       = 16'h0064;
	localparam logic [15:0] RST_OVF1      = 16'h0064;
	localparam logic [15:0] RST_OSP1      = 16'h0000;
	localparam logic [15:0] RST_TQ2       = 16'h0064;
	localparam logic [15:0] RST_OVF2      = 16'h0064;
	localparam logic [15:0] RST_OSP2      = 16'h0000;

	localparam logic [15:0] MAX_SPEED     = 16'h1770;
	localparam logic [15:0] MAX_TORQUE    = 16'h01F4;
	localparam logic [15:0] MAX_OVF       = 16'h7FFF;
	localparam logic [15:0] MIN_OVF2      = 16'h0001;
	localparam logic [7:0]  REGEN_LIMIT   = 8'h0A;
	localparam logic [7:0]  ALARM_REGEN   = 8'h12;
	localparam int          OVF_SHIFT     = 8;

	localparam int IRQ_REGEN = 0;
	localparam int IRQ_OSPD  = 1;
	localparam int IRQ_OVF   = 2;
	localparam int IRQ_W     = 3;

	typedef enum logic [1:0] {
		REGEN_CAP_A,
		REGEN_EXT_ALARM,
		REGEN_EXT_NOALARM,
		REGEN_CAP_B
	} dlsp_regen_t;

	typedef struct packed {
		logic [15:0] torque_pct;
		logic [15:0] ovf_level;
		logic [15:0] ospd_level;
	} dlsp_set_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} dlsp_apb_req_t;

	function automatic logic [15:0] dlsp_clamp(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		if (v > hi)
			return hi;
		else if (v < lo)
			return lo;
		return v;
	endfunction

	function automatic logic [31:0] dlsp_ovf_pulses(input logic [15:0] lvl);
		return {8'h00, lvl, 8'h00};
	endfunction
endpackage

// File: hdl/dlsp_set_check.sv
// Purpose: pick the active limit set and compare speed and deviation to it
// Assumes: speed and deviation are magnitudes, synchronous to mclk
// Notes: outputs are registered, one cycle behind the inputs
`timescale 1ns/1ps
module dlsp_set_check
	import dlsp_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// limit sets and selection
	input  wire dlsp_set_t   set_one,
	input  wire dlsp_set_t   set_two,
	input  wire logic        switch_en,
	input  wire logic        second_sel,
	// measurements
	input  wire logic [15:0] speed_rpm,
	input  wire logic [31:0] deviation,
	// results
	output dlsp_set_t        active_set,
	output logic [31:0]      ovf_pulses,
	output logic             use_second,
	output logic             overspeed,
	output logic             overflow
);
	logic      pick_two;
	dlsp_set_t pick;

	// one selection drives the whole set so limits never mix
	assign pick_two = switch_en & second_sel;
	assign pick     = pick_two ? set_two : set_one;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			active_set <= '0;
			ovf_pulses <= '0;
			use_second <= 1'b0;
		end else begin
			active_set <= pick;
			ovf_pulses <= dlsp_ovf_pulses(pick.ovf_level);
			use_second <= pick_two;
		end
	end

	// overspeed check exists only with switching on; off, both levels are ignored
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			overspeed <= 1'b0;
		else
			overspeed <= switch_en & (speed_rpm > pick.ospd_level);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			overflow <= 1'b0;
		else
			overflow <= deviation > dlsp_ovf_pulses(pick.ovf_level);
	end
endmodule

// File: sim/dlsp_checker.sv
// Purpose: port-level assertions for the limit-set and protection block
// Assumes: one clock domain, active-low asynchronous reset
// Notes: configuration is hidden, so outputs are tied to each other
`timescale 1ns/1ps
module dlsp_checker
	import dlsp_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        rstn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	// measurements
	input wire logic [31:0] deviation,
	input wire logic [7:0]  regen_load_pct,
	input wire logic        second_torque_sel,
	// results
	input wire logic        regen_ext_en,
	input wire logic        regen_alarm,
	input wire logic [7:0]  alarm_code,
	input wire logic [15:0] torque_limit,
	input wire logic [31:0] ovf_threshold,
	input wire logic        overflow_err,
	input wire logic        second_set_active
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// $past guard: the first edge after reset still sees reset values
	sequence alarm_seen;
		$past(rstn) && regen_alarm;
	endsequence
	sequence load_was_high;
		$past(regen_load_pct) > REGEN_LIMIT;
	endsequence
	ready_nowait_a: assert property (pready == (psel && penable))
		else $error("pready not in access phase");
	slverr_access_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	alarm_code_a: assert property (alarm_code == (regen_alarm ? ALARM_REGEN : 8'h00))
		else $error("alarm code does not match regen alarm");
	alarm_ext_a: assert property (regen_alarm |-> regen_ext_en)
		else $error("regen alarm without external resistor");
	alarm_load_a: assert property (alarm_seen |-> load_was_high)
		else $error("regen alarm at load not above limit");
	ovf_scale_a: assert property (ovf_threshold[7:0] == 8'h00 &&
		ovf_threshold[31:23] == 9'h000)
		else $error("overflow threshold not a multiple of 256");
	ovf_compare_a: assert property ($past(rstn) |->
		overflow_err == ($past(deviation) > ovf_threshold))
		else $error("overflow error disagrees with threshold");
	torque_max_a: assert property (torque_limit <= MAX_TORQUE)
		else $error("torque limit above maximum");
	set_follow_a: assert property (second_set_active |-> $past(second_torque_sel))
		else $error("second set active without selection");
endmodule

bind dlsp_limit_protect dlsp_checker chk_u (.mclk(mclk), .rstn(rstn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .deviation(deviation),
	.regen_load_pct(regen_load_pct), .second_torque_sel(second_torque_sel),
	.regen_ext_en(regen_ext_en), .regen_alarm(regen_alarm), .alarm_code(alarm_code),
	.torque_limit(torque_limit), .ovf_threshold(ovf_threshold),
	.overflow_err(overflow_err), .second_set_active(second_set_active));

// File: sim/dlsp_limit_protect_bench.sv
// Purpose: self-checking bench for the limit-set and protection block
// Assumes: zero-wait APB slave, one-cycle output latency
// Notes: directed tests only
`timescale 1ns/1ps
module dlsp_limit_protect_bench
	import dlsp_pkg::*;
;
	logic          mclk, rstn, sel2, pready, pslverr, rerr;
	logic          ext_en, alarm, ospd, ovf, set2, irq;
	logic [7:0]    code, load_tgt, load;
	logic [15:0]   tq, speed_tgt, speed;
	logic [31:0]   prdata, rdat, thr, dev_tgt, dev;
	logic [15:0]   rst_tab [10];
	dlsp_apb_req_t req;
	int            err_count, n_tests, k;

	dlsp_motor_model motor (.mclk(mclk), .speed_tgt(speed_tgt), .dev_tgt(dev_tgt),
		.load_tgt(load_tgt), .speed_rpm(speed), .deviation(dev), .regen_load_pct(load));
	dlsp_limit_protect DUT (.mclk(mclk), .rstn(rstn), .psel(req.psel),
		.penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr),
		.pwdata(req.pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.speed_rpm(speed), .deviation(dev), .regen_load_pct(load),
		.second_torque_sel(sel2), .regen_ext_en(ext_en), .regen_alarm(alarm),
		.alarm_code(code), .torque_limit(tq), .ovf_threshold(thr),
		.overspeed_err(ospd), .overflow_err(ovf), .second_set_active(set2), .irq(irq));

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// wide enough for the longest packed compare, so no flag is cut off
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		#1;
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		for (i = 0; i < 8; i++) begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		rdat = prdata;
		rerr = pslverr;
		req <= '0;
		if (i == 8) begin
			err_count++;
			$display("Error at %0t: no pready", $time);
			report_and_stop();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdat, exp);
	endtask

	// fixed wait: one edge in the model, one in the design, then margin
	task automatic drive(input logic [15:0] s, input logic [31:0] dv, input logic [7:0] ld,
		input logic sl);
		@(posedge mclk);
		speed_tgt <= s;
		dev_tgt <= dv;
		load_tgt <= ld;
		sel2 <= sl;
		repeat (4) @(posedge mclk);
	endtask

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		rstn = 1'b0;
		req = '0;
		{sel2, speed_tgt, dev_tgt, load_tgt} = '0;
		rst_tab = '{16'h0000, 16'h0000, RST_TQ1, RST_OVF1, RST_OSP1, RST_TQ2, RST_OVF2,
			RST_OSP2, 16'h0000, 16'h0000};
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		for (k = 0; k < 10; k++)
			rd(8'(4 * k), {16'h0000, rst_tab[k]});
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk({rerr, rdat}, {1'b1, 32'h0000_0000});
		$display("test reset and unmapped done");
		apb(1'b1, OFS_OSP1, 32'h0000_1771);
		rd(OFS_OSP1, 32'h0000_1770);
		apb(1'b1, OFS_TQ2, 32'h0000_01F5);
		rd(OFS_TQ2, 32'h0000_01F4);
		apb(1'b1, OFS_OVF2, 32'h0000_0000);
		rd(OFS_OVF2, 32'h0000_0001);
		$display("test clamping done");
		for (k = 0; k < 4; k++) begin
			apb(1'b1, OFS_REGEN_SEL, 32'(k));
			drive(16'h0000, 32'h0000_0000, 8'h0B, 1'b0);
			chk({ext_en, alarm, code}, {k[0] ^ k[1], k == 1, (k == 1) ? 8'h12 : 8'h00});
			drive(16'h0000, 32'h0000_0000, 8'h0A, 1'b0);
			chk(alarm, 1'b0);
		end
		$display("test regeneration modes done");
		apb(1'b1, OFS_OSP1, 32'h0000_03E8);
		apb(1'b1, OFS_OSP2, 32'h0000_07D0);
		apb(1'b1, OFS_TQ1, 32'h0000_00C8);
		apb(1'b1, OFS_TQ2, 32'h0000_012C);
		apb(1'b1, OFS_OVF2, 32'h0000_0032);
		drive(16'h0BB8, 32'h0000_0000, 8'h00, 1'b1);
		chk({ospd, set2, tq}, {2'b00, 16'h00C8});
		apb(1'b1, OFS_LIMIT_SW, 32'h0000_0001);
		drive(16'h03E9, 32'h0000_6401, 8'h00, 1'b0);
		chk({ospd, ovf, thr}, {2'b11, 32'h0000_6400});
		drive(16'h03E8, 32'h0000_6400, 8'h00, 1'b0);
		chk({ospd, ovf}, 2'b00);
		drive(16'h07D0, 32'h0000_3201, 8'h00, 1'b1);
		chk({ospd, ovf, set2, tq, thr}, {3'b011, 16'h012C, 32'h0000_3200});
		drive(16'h07D1, 32'h0000_3200, 8'h00, 1'b1);
		chk({ospd, ovf}, 2'b10);
		rd(OFS_LIVE, 32'h0000_0022);
		$display("test limit sets done");
		rd(OFS_IRQ_STAT, 32'h0000_0007);
		chk(irq, 1'b0);
		apb(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
		rd(OFS_IRQ_MASK, 32'h0000_0002);
		chk(irq, 1'b1);
		drive(16'h0000, 32'h0000_0000, 8'h00, 1'b0);
		apb(1'b1, OFS_IRQ_STAT, 32'h0000_0007);
		rd(OFS_IRQ_STAT, 32'h0000_0000);
		chk(irq, 1'b0);
		$display("test interrupt done");
		report_and_stop();
	end
endmodule

// File: sim/dlsp_motor_model.sv
// Purpose: motor side model feeding speed, deviation and resistor load
// Assumes: bench sets targets; feedback follows one edge later
// Notes: magnitudes only, no noise
`timescale 1ns/1ps
module dlsp_motor_model (
	// clock
	input wire logic  mclk,
	// targets
	input wire logic [15:0] speed_tgt,
	input wire logic [31:0] dev_tgt,
	input wire logic [7:0]  load_tgt,
	// feedback
	output logic [15:0]     speed_rpm,
	output logic [31:0]     deviation,
	output logic [7:0]      regen_load_pct
);
	// feedback is sampled on the control tick, never mid-cycle
	always_ff @(posedge mclk) begin
		speed_rpm <= speed_tgt;
		deviation <= dev_tgt;
		regen_load_pct <= load_tgt;
	end
endmodule
